/* File: dv/efm_enc_model.sv */
// Purpose: Behavioural serial position encoder at the far side of the link
// Assumes: One frame per rising edge of link_req; 125 ns link clock period
// Notes: Clock stands low outside frames; idle data shows the inverse of the last bit
`default_nettype none
module efm_enc_model (
   input wire logic link_req,
   input wire logic [15:0] pos,
   input wire logic start_v,
   input wire logic stat_v,
   input wire logic mute,
   output logic link_clk,
   output logic link_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [17:0] bits;
   // A muted encoder models a broken link: no clock, no data
   // One process drives both pins so each has a single driver
   initial begin
      link_clk = 1'b0;
      link_data = 1'b1;
      forever begin
         @(posedge link_req);
         if (!mute) begin
            bits = {start_v, pos, stat_v};
            for (int i = 17; i >= 0; i--) begin
               link_data = bits[i];
               #62.5 link_clk = 1'b1;
               #62.5 link_clk = 1'b0;
            end
            link_data = ~bits[0];
         end
      end
   end
endmodule // efm_enc_model
`default_nettype wire

/* File: dv/tb_encoder_fault_monitor.sv */
// Purpose: Self-checking bench of the encoder fault monitor
// Assumes: Register map and fault codes of efm_map.svh
// Notes: Short once-per-second tick of 200 cycles; a link frame outlasts it, so link frames come every 400 cycles
`include "efm_map.svh"
`default_nettype none
module tb_encoder_fault_monitor;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] ID_V = 16'h0123; // Arbitrary value
   localparam logic [15:0] VER_V = 16'h0412; // Arbitrary value
   logic clk, rst_b, reg_wr, reg_rd, sample_en, wb_a, wb_b, wb_z, psu_short, fitted, mute, start_v, stat_v;
   logic [7:0] reg_addr, fault_code;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] inc_pos, comm_pos, analog_pos, nv_in, nv_out, enc_pos;
   logic signed [11:0] sin_lvl, cos_lvl;
   logic [2:0] term_en;
   logic link_clk, link_data, link_req, enc_reinit, autocfg_req, nv_save, slot_trip, irq;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;

   efm_monitor #(.CHECK_CYCLES(200), .MODULE_ID(ID_V), .SW_VERSION(VER_V)) u_dut (
      .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_en(sample_en), .inc_pos(inc_pos),
      .comm_pos(comm_pos), .analog_pos(analog_pos), .sin_lvl(sin_lvl), .cos_lvl(cos_lvl),
      .wb_a_pin(wb_a), .wb_b_pin(wb_b), .wb_z_pin(wb_z), .psu_short_pin(psu_short),
      .link_clk(link_clk), .link_data(link_data), .slot_fitted_pin(fitted), .nv_code_in(nv_in),
      .term_en(term_en), .link_req(link_req), .enc_reinit(enc_reinit), .autocfg_req(autocfg_req),
      .nv_save(nv_save), .nv_code_out(nv_out), .slot_mismatch_trip(slot_trip),
      .fault_code(fault_code), .irq(irq));
   efm_enc_model u_enc (.link_req(link_req), .pos(enc_pos), .start_v(start_v), .stat_v(stat_v),
      .mute(mute), .link_clk(link_clk), .link_data(link_data));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic close_out();
      if (miscompares == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(nm, e, reg_rdata);
   endtask
   task automatic samp(input int n);
      repeat (n) begin
         @(posedge clk);
         sample_en <= 1'b1;
         @(posedge clk);
         sample_en <= 1'b0;
      end
      cyc(4);
   endtask
   // Fault reset; the encoder restart pulse stands in the cycle after the write
   task automatic frst(input logic acfg);
      wr(`EFM_A_CMD, 32'h1);
      #1 chk("enc_reinit", 1, enc_reinit);
      chk("autocfg_req", acfg, autocfg_req);
      chk("fault_code", 0, fault_code);
   endtask
   task automatic frame();
      int n;
      n = 0;
      while (!link_req && n < 2000) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (link_req && n < 2500) begin
         @(posedge clk);
         n++;
      end
      cyc(4);
   endtask
   task automatic rst(input logic f, input logic [15:0] nv);
      @(posedge clk);
      rst_b <= 1'b0;
      fitted <= f;
      nv_in <= nv;
      cyc(8);
      rst_b <= 1'b1;
      cyc(6);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rd(`EFM_A_ID, {16'h0, ID_V}, "id");
      rd(`EFM_A_SWVER, {16'h0, VER_V}, "swver");
      rd(`EFM_A_FAULT, 0, "fault");
      rd(`EFM_A_CTRL, `EFM_CTRL_RESET, "ctrl");
      chk("term_en", 3'b011, term_en);
      rd(8'h3c, 0, "unmapped");
      wr(`EFM_A_ID, 32'hffff);
      rd(`EFM_A_ID, {16'h0, ID_V}, "id_ro");
      chk("slot_trip", 0, slot_trip);
   endtask
   task automatic t_wire();
      wr(`EFM_A_IRQ_EN, 32'h1);
      wb_z <= 1'b1;
      cyc(6);
      chk("fault_z_off", 0, fault_code);
      wb_z <= 1'b0;
      wr(`EFM_A_CTRL, 32'h1630);
      wb_a <= 1'b1;
      cyc(6);
      chk("fault_trip_off", 0, fault_code);
      wr(`EFM_A_CTRL, 32'h1730);
      cyc(6);
      chk("fault_wire", `EFM_FC_WIRE, fault_code);
      chk("irq", 1, irq);
      wb_a <= 1'b0;
      cyc(4);
      frst(1'b0);
      chk("irq_sticky", 1, irq);
      wr(`EFM_A_IRQ_CLR, 32'h1);
      #1 chk("irq_clr", 0, irq);
   endtask
   task automatic t_phase();
      wr(`EFM_A_CTRL, 32'h1533);
      comm_pos <= 16'd4000;
      samp(12);
      chk("phase_trip_off", 0, fault_code);
      comm_pos <= 16'd0;
      samp(1);
      wr(`EFM_A_CTRL, 32'h1733);
      comm_pos <= 16'd4000;
      samp(9);
      chk("phase_9", 0, fault_code);
      samp(1);
      chk("phase_10", `EFM_FC_WIRE, fault_code);
      comm_pos <= 16'd0;
      frst(1'b0);
   endtask
   task automatic t_sine();
      wr(`EFM_A_CTRL, 32'h1734);
      sin_lvl <= 12'sd125;
      cos_lvl <= 12'sd0;
      samp(2);
      chk("sine_edge", 0, fault_code);
      sin_lvl <= 12'sd80;
      cos_lvl <= 12'sd80;
      samp(1);
      chk("sine_low", `EFM_FC_WIRE, fault_code);
      sin_lvl <= 12'sd500;
      cos_lvl <= 12'sd500;
      frst(1'b0);
   endtask
   task automatic t_link();
      wr(`EFM_A_IRQ_CLR, 32'h7);
      wr(`EFM_A_IRQ_EN, 32'h4);
      wr(`EFM_A_CTRL, 32'h1736);
      frame();
      rd(`EFM_A_IRQ_STAT, 32'h4, "good_frame");
      chk("irq_frame", 1, irq);
      analog_pos <= enc_pos + 16'd4000;
      repeat (9) frame();
      chk("comms_phase_9", 0, fault_code);
      frame();
      chk("comms_phase_10", `EFM_FC_SCPH, fault_code);
      analog_pos <= enc_pos;
      frst(1'b0);
      stat_v <= 1'b1;
      frame();
      chk("supply_bit", `EFM_FC_PSU, fault_code);
      stat_v <= 1'b0;
      start_v <= 1'b0;
      wr(`EFM_A_CTRL, 32'h3736);
      frst(1'b1);
      frame();
      chk("start_bit", `EFM_FC_CHK, fault_code);
      start_v <= 1'b1;
      mute <= 1'b1;
      frst(1'b1);
      frame();
      chk("timeout", `EFM_FC_TMO, fault_code);
      mute <= 1'b0;
      // Without supply monitor the status bit is even parity; 0x1234 needs a one
      wr(`EFM_A_CTRL, 32'h2736);
      frst(1'b1);
      frame();
      chk("parity", `EFM_FC_CHK, fault_code);
      stat_v <= 1'b1;
      // Clear the latched code so the short in the next scenario can latch
      frst(1'b1);
   endtask
   task automatic t_slot();
      psu_short <= 1'b1;
      cyc(6);
      chk("short", `EFM_FC_SHORT, fault_code);
      psu_short <= 1'b0;
      rst(1'b1, 16'h0000);
      rd(`EFM_A_FAULT, 0, "fault_rst");
      chk("slot_diff", 1, slot_trip);
      rd(`EFM_A_STATUS, 32'h3, "unsaved");
      rd(`EFM_A_CTRL, `EFM_CTRL_RESET, "ctrl_dflt");
      wr(`EFM_A_CMD, 32'h2);
      #1 chk("nv_save", 1, nv_save);
      cyc(2);
      chk("nv_code_out", {16'h0, ID_V}, nv_out);
      rd(`EFM_A_STATUS, 0, "saved");
      rst(1'b0, ID_V);
      rd(`EFM_A_ID, 0, "id_empty");
      chk("slot_empty", 1, slot_trip);
   endtask

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      {reg_wr, reg_rd, sample_en, wb_a, wb_b, wb_z, psu_short, mute, stat_v} = '0;
      {fitted, start_v} = 2'b11;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      {inc_pos, comm_pos} = '0;
      enc_pos = 16'h1234;
      analog_pos = 16'h1234;
      nv_in = ID_V;
      sin_lvl = 12'sd500;
      cos_lvl = 12'sd500;
      cyc(8);
      rst_b <= 1'b1;
      cyc(6);
      t_reset();
      t_wire();
      t_phase();
      t_sine();
      t_link();
      t_slot();
      close_out();
   end
endmodule // tb_encoder_fault_monitor
`default_nettype wire

/* File: hw/efm_monitor.sv */
// Purpose: Encoder fault supervision: wire break, phase error, serial link checks
// Assumes: sample_en, positions and sine/cosine levels come from logic on clk
// Notes: First fault latches until a fault reset or drive reset
//
// Implementation choices: the plain strobed port and the address map.
`include "efm_map.svh"
`default_nettype none
module efm_monitor #(
   parameter int unsigned POS_W = 16,
   parameter int unsigned ADC_W = 12,
   parameter int unsigned UV_PER_LSB = 1000,
   parameter int unsigned CHECK_CYCLES = `EFM_CHECK_NS / `EFM_CLK_NS,
   parameter logic [15:0] MODULE_ID = 16'h0123, // Arbitrary value
   parameter logic [15:0] SW_VERSION = 16'h0100 // Arbitrary value
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic sample_en,
   input wire logic [POS_W-1:0] inc_pos,
   input wire logic [POS_W-1:0] comm_pos,
   input wire logic [POS_W-1:0] analog_pos,
   input wire logic signed [ADC_W-1:0] sin_lvl,
   input wire logic signed [ADC_W-1:0] cos_lvl,
   input wire logic wb_a_pin,
   input wire logic wb_b_pin,
   input wire logic wb_z_pin,
   input wire logic psu_short_pin,
   input wire logic link_clk,
   input wire logic link_data,
   input wire logic slot_fitted_pin,
   input wire logic [15:0] nv_code_in,
   output logic [2:0] term_en,
   output logic link_req,
   output logic enc_reinit,
   output logic autocfg_req,
   output logic nv_save,
   output logic [15:0] nv_code_out,
   output logic slot_mismatch_trip,
   output logic [7:0] fault_code,
   output logic irq
);
   // ----------------------------------------
   // Derived constants
   // ----------------------------------------
   localparam int unsigned FB = POS_W + 2;
   localparam int unsigned TMO = `EFM_LINK_TMO_NS / `EFM_CLK_NS;
   localparam int unsigned PK = `EFM_WB_PP_UV / 2 / UV_PER_LSB;
   localparam logic [2*ADC_W:0] WB_MIN = (2*ADC_W+1)'(PK * PK);
   localparam logic [POS_W-1:0] PH_TOL = POS_W'((`EFM_PHASE_DEG * (64'd1 << POS_W)) / 360);
   localparam int SW = $clog2(CHECK_CYCLES);
   localparam int TW = $clog2(TMO);
   localparam int BW = $clog2(FB);

   function automatic logic [POS_W-1:0] pos_dist(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
      logic [POS_W-1:0] d;
      d = a - b;
      pos_dist = d[POS_W-1] ? POS_W'(-d) : d;
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [6:0] sy1_q, sy2_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sy1_q <= 7'h00;
         sy2_q <= 7'h00;
      end else begin
         sy1_q <= {slot_fitted_pin, link_data, link_clk, psu_short_pin, wb_z_pin, wb_b_pin, wb_a_pin};
         sy2_q <= sy1_q;
      end
   end
   wire logic [2:0] wb_s = sy2_q[2:0];
   wire logic short_s = sy2_q[3];
   wire logic lclk_s = sy2_q[4];
   wire logic ldat_s = sy2_q[5];
   wire logic fitted_s = sy2_q[6];

   // ----------------------------------------
   // Registers and commands
   // ----------------------------------------
   logic [31:0] ctrl_q;
   logic [2:0] irq_stat_q, irq_en_q;
   logic [1:0] init_q;
   logic [15:0] ident_q, swver_q;
   logic unsaved_q, slot_mm_q;
   logic [7:0] fault_q;
   wire logic wr_ctrl = reg_wr && reg_addr == `EFM_A_CTRL;
   wire logic wr_cmd = reg_wr && reg_addr == `EFM_A_CMD;
   wire logic f_reset = wr_cmd && reg_wdata[`EFM_CMD_FRESET];
   wire logic save = wr_cmd && reg_wdata[`EFM_CMD_SAVE];
   wire logic capture = init_q == 2'h2;
   wire logic [15:0] ident_d = fitted_s ? MODULE_ID : 16'h0000;
   wire logic mm_d = nv_code_in != ident_d;
   efm_pkg::efm_enc_t etype;
   assign etype = efm_pkg::efm_enc_t'(ctrl_q[`EFM_CTRL_TYPE]);
   wire logic [2:0] trip_en = ctrl_q[`EFM_CTRL_TRIP];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl_q <= `EFM_CTRL_RESET;
      end else if (capture && mm_d) begin
         ctrl_q <= `EFM_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= reg_wdata & `EFM_CTRL_MASK;
      end
   end
   assign term_en = ctrl_q[`EFM_CTRL_TERM];

   // Straps are read only once they have crossed both synchroniser stages
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         init_q <= 2'h0;
         ident_q <= 16'h0000;
         swver_q <= 16'h0000;
      end else if (init_q != 2'h3) begin
         init_q <= init_q + 2'h1;
         if (capture) begin
            ident_q <= ident_d;
            swver_q <= SW_VERSION;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         unsaved_q <= 1'b0;
         slot_mm_q <= 1'b0;
         nv_save <= 1'b0;
         nv_code_out <= 16'h0000;
      end else begin
         nv_save <= save;
         if (save) begin
            nv_code_out <= ident_q;
            unsaved_q <= 1'b0;
            slot_mm_q <= 1'b0;
         end else if (capture && mm_d) begin
            unsaved_q <= 1'b1;
            slot_mm_q <= 1'b1;
         end
      end
   end
   assign slot_mismatch_trip = slot_mm_q;

   // ----------------------------------------
   // Incremental wire break and phase check
   // ----------------------------------------
   wire logic hw_type = etype == efm_pkg::quadrature_type || etype == efm_pkg::freq_dir_type ||
      etype == efm_pkg::fwd_rev_type || etype == efm_pkg::quadrature_commutation_type ||
      etype == efm_pkg::sincos_commutation_type;
   wire logic servo = etype == efm_pkg::quadrature_commutation_type ||
      etype == efm_pkg::sincos_commutation_type;
   wire logic sc_type = etype == efm_pkg::sincos_type || etype == efm_pkg::sincos_commutation_type ||
      etype == efm_pkg::sincos_synchronous_serial_type;
   wire logic ssi_type = etype == efm_pkg::sincos_synchronous_serial_type;
   wire logic hw_wb = hw_type && trip_en[`EFM_TRIP_WB] && |(wb_s & term_en);

   logic [3:0] ph_cnt_q;
   wire logic ph_bad = pos_dist(inc_pos, comm_pos) > PH_TOL;
   wire logic ph_trip = servo && sample_en && ph_bad && ph_cnt_q == `EFM_PHASE_SAMPLES - 4'h1;
   always_ff @(posedge clk) begin
      if (!rst_b || f_reset) begin
         ph_cnt_q <= 4'h0;
      end else if (sample_en) begin
         if (servo && ph_bad && ph_cnt_q != `EFM_PHASE_SAMPLES) begin
            ph_cnt_q <= ph_cnt_q + 4'h1;
         end else if (!(servo && ph_bad)) begin
            ph_cnt_q <= 4'h0;
         end
      end
   end

   // Squares are formed combinationally; width keeps the full sum
   wire logic [2*ADC_W-1:0] sin_sq = (2*ADC_W)'(sin_lvl * sin_lvl);
   wire logic [2*ADC_W-1:0] cos_sq = (2*ADC_W)'(cos_lvl * cos_lvl);
   wire logic [2*ADC_W:0] sq_sum = {1'b0, sin_sq} + {1'b0, cos_sq};
   wire logic sc_wb = sc_type && sample_en && sq_sum < WB_MIN;

   // ----------------------------------------
   // Once-per-second serial position read
   // ----------------------------------------
   logic [SW-1:0] sec_q;
   wire logic sec_tick = sec_q == SW'(CHECK_CYCLES - 1);
   always_ff @(posedge clk) begin
      if (!rst_b || sec_tick) begin
         sec_q <= '0;
      end else begin
         sec_q <= sec_q + SW'(1);
      end
   end

   efm_pkg::efm_link_st_t lk_q;
   logic [BW-1:0] bit_q;
   logic [TW-1:0] tmo_q;
   logic [FB-1:0] sh_q;
   logic lclk_prev_q, reinit_q;
   wire logic lrise = lclk_s && !lclk_prev_q;
   wire logic last_bit = lk_q == efm_pkg::LK_BITS && lrise && bit_q == BW'(FB - 1);
   wire logic lk_tmo = lk_q == efm_pkg::LK_BITS && !last_bit && tmo_q == TW'(TMO - 1);
   wire logic [FB-1:0] frame = {sh_q[FB-2:0], ldat_s};
   wire logic [POS_W-1:0] fpos = frame[POS_W:1];
   wire logic st_bad = last_bit && !frame[FB-1];
   wire logic ssimon = ctrl_q[`EFM_CTRL_SSIMON];
   wire logic par_bad = last_bit && !ssimon && (^fpos != frame[0]);
   wire logic psu_bad = last_bit && ssimon && frame[0] && trip_en[`EFM_TRIP_PSU];
   wire logic f_ok = last_bit && !st_bad && !par_bad && !psu_bad;
   wire logic lk_start = lk_q == efm_pkg::LK_IDLE && ssi_type && fault_q == 8'h00 && (sec_tick || reinit_q);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lk_q <= efm_pkg::LK_IDLE;
         bit_q <= '0;
         tmo_q <= '0;
         sh_q <= '0;
         lclk_prev_q <= 1'b0;
      end else begin
         lclk_prev_q <= lclk_s;
         case (lk_q)
            efm_pkg::LK_IDLE: begin
               if (lk_start) begin
                  lk_q <= efm_pkg::LK_BITS;
                  bit_q <= '0;
                  tmo_q <= '0;
               end
            end
            efm_pkg::LK_BITS: begin
               tmo_q <= tmo_q + TW'(1);
               if (lrise) begin
                  sh_q <= frame;
                  bit_q <= bit_q + BW'(1);
               end
               if (last_bit || lk_tmo) begin
                  lk_q <= efm_pkg::LK_IDLE;
               end
            end
            default: lk_q <= efm_pkg::LK_IDLE;
         endcase
      end
   end
   assign link_req = lk_q == efm_pkg::LK_BITS;

   logic [3:0] sc_cnt_q;
   wire logic sc_bad = pos_dist(fpos, analog_pos) > PH_TOL;
   wire logic sc_trip = f_ok && sc_bad && trip_en[`EFM_TRIP_PH] && sc_cnt_q == `EFM_PHASE_SAMPLES - 4'h1;
   always_ff @(posedge clk) begin
      if (!rst_b || f_reset) begin
         sc_cnt_q <= 4'h0;
      end else if (f_ok) begin
         sc_cnt_q <= sc_bad ? sc_cnt_q + 4'h1 : 4'h0;
      end
   end

   // ----------------------------------------
   // Fault status
   // ----------------------------------------
   logic [7:0] det;
   always_comb begin
      det = 8'h00;
      if (short_s) begin
         det = `EFM_FC_SHORT;
      end else if (hw_wb || sc_wb || (ph_trip && trip_en[`EFM_TRIP_PH])) begin
         det = `EFM_FC_WIRE;
      end else if (sc_trip) begin
         det = `EFM_FC_SCPH;
      end else if (lk_tmo) begin
         det = `EFM_FC_TMO;
      end else if (st_bad || par_bad) begin
         det = `EFM_FC_CHK;
      end else if (psu_bad) begin
         det = `EFM_FC_PSU;
      end
   end
   wire logic f_set = det != 8'h00 && (fault_q == 8'h00 || f_reset);

   // A new fault in the clearing cycle wins over the clear
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         fault_q <= 8'h00;
      end else if (f_set) begin
         fault_q <= det;
      end else if (f_reset) begin
         fault_q <= 8'h00;
      end
   end
   assign fault_code = fault_q;

   wire logic reinit = f_reset && fault_q != 8'h00 && fault_q <= `EFM_FC_REINIT_MAX;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reinit_q <= 1'b0;
         enc_reinit <= 1'b0;
         autocfg_req <= 1'b0;
      end else begin
         reinit_q <= reinit;
         enc_reinit <= reinit;
         autocfg_req <= reinit && ctrl_q[`EFM_CTRL_AUTOCFG];
      end
   end

   // ----------------------------------------
   // Interrupts and read port
   // ----------------------------------------
   wire logic [2:0] ev = {f_ok, capture && mm_d, f_set};
   wire logic [2:0] clr = (reg_wr && reg_addr == `EFM_A_IRQ_CLR) ? reg_wdata[2:0] : 3'h0;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq_stat_q <= 3'h0;
         irq_en_q <= 3'h0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~clr) | ev;
         if (reg_wr && reg_addr == `EFM_A_IRQ_EN) begin
            irq_en_q <= reg_wdata[2:0];
         end
      end
   end
   assign irq = |(irq_stat_q & irq_en_q);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `EFM_A_ID: reg_rdata <= {16'h0000, ident_q};
            `EFM_A_SWVER: reg_rdata <= {16'h0000, swver_q};
            `EFM_A_FAULT: reg_rdata <= {24'h000000, fault_q};
            `EFM_A_CTRL: reg_rdata <= ctrl_q;
            `EFM_A_STATUS: reg_rdata <= {29'h0, link_req, unsaved_q, slot_mm_q};
            `EFM_A_IRQ_STAT: reg_rdata <= {29'h0, irq_stat_q};
            `EFM_A_IRQ_EN: reg_rdata <= {29'h0, irq_en_q};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_TRIP_GATE: assert property (det == `EFM_FC_PSU |-> trip_en[`EFM_TRIP_PSU])
      else $error("supply trip raised while disabled");
   AST_WB_TERM: assert property (hw_wb |-> |(wb_s & term_en) && hw_type)
      else $error("wire break without termination");
   AST_Z_DEFAULT: assert property ($rose(init_q == 2'h1) |-> !term_en[2])
      else $error("Z termination on after reset");
   AST_PH_TEN: assert property (ph_trip |-> $past(ph_cnt_q) <= ph_cnt_q && ph_cnt_q == 4'h9)
      else $error("phase trip before ten samples");
   AST_SEC_REQ: assert property ($rose(link_req) |-> $past(sec_tick) || $past(reinit_q))
      else $error("link read outside check tick");
   AST_REINIT: assert property (f_reset && fault_q inside {[8'h01:8'h08]} |=> enc_reinit ##1 !enc_reinit)
      else $error("no single reinit pulse on fault reset");
   AST_SSI_PSU: assert property (last_bit && ssimon && frame[FB-1] && frame[0] && trip_en[2]
      && fault_q == 8'h00 && det == `EFM_FC_PSU |=> fault_q == `EFM_FC_PSU)
      else $error("supply bit not trapped");
   AST_IDENT: assert property (capture |=> ident_q == $past(ident_d) [*3])
      else $error("identity not held");
   AST_HOLD: assert property (fault_q == 8'h00 && det == 8'h00 |=> fault_q == 8'h00)
      else $error("fault status changed with no fault");
   AST_LATCH: assert property (fault_q != 8'h00 && !f_reset |=> fault_q == $past(fault_q))
      else $error("fault code not latched");

   COV_WIRE: cover property (fault_q == 8'h00 ##1 fault_q == `EFM_FC_WIRE);
   COV_PHASE: cover property (ph_trip);
   COV_FRAME: cover property (f_ok);
   COV_REINIT: cover property (enc_reinit);
endmodule // efm_monitor
`default_nettype wire

/* File: shared/efm_map.svh */
// Purpose: Constants of the encoder fault monitor: offsets, fields, resets, timing
// Assumes: Included by bare name; definitions only
// Notes: Byte addresses on a 32-bit register port
//
// Overview of operation
// - Optional trips (wire break, phase error, supply failure) each gated by a trip enable, except sine/cosine wire break, which is never gated.
// - Hardware wire break on A, B or Z ignored while that line's termination is off.
// - After reset the Z termination is off, so Z wire break is disabled.
// - Servo incremental: count versus commutation mismatch for 10 samples trips.
// - Sine/cosine with comms: read link once per second, 10 mismatches trip.
// - Resetting fault codes 1 to 8 re-initialises the encoder, autoconfig if selected.
// - Drive reset clears fault status to zero.
// - Incremental and servo types report hardware wire break as code 2.
// - Sine/cosine wire break when sin squared plus cos squared below 0.25V pp level.
// - Broken serial link shows as check error (code 5) or timeout (code 4).
// - Supply monitor: start bit must be one, supply bit zero, else code 5 or 6.
// - Module identity written at power-up, up to 599, zero with an empty slot.
// - With a module fitted the identity shows its identification code.
// - Save stores the option code; a different one at power-up raises slot mismatch.
// - After category change defaults appear but stay unsaved until a save.
// - Software version read-only, 00.00 to 99.99, written at power-up.
// - Fault status is read-only 0 to 255 holding the fault code.
`ifndef EFM_MAP_SVH
`define EFM_MAP_SVH
`define EFM_A_ID 8'h00
`define EFM_A_SWVER 8'h04
`define EFM_A_FAULT 8'h08
`define EFM_A_CTRL 8'h0c
`define EFM_A_CMD 8'h10
`define EFM_A_STATUS 8'h14
`define EFM_A_IRQ_STAT 8'h18
`define EFM_A_IRQ_EN 8'h1c
`define EFM_A_IRQ_CLR 8'h20
`define EFM_CTRL_RESET 32'h0000_1730
`define EFM_CTRL_TYPE 2:0
`define EFM_CTRL_TERM 6:4
`define EFM_CTRL_TRIP 10:8
`define EFM_CTRL_SSIMON 12
`define EFM_CTRL_AUTOCFG 13
`define EFM_CTRL_MASK 32'h0000_3777
`define EFM_CMD_FRESET 0
`define EFM_CMD_SAVE 1
`define EFM_TRIP_WB 0
`define EFM_TRIP_PH 1
`define EFM_TRIP_PSU 2
`define EFM_FC_SHORT 8'h01
`define EFM_FC_WIRE 8'h02
`define EFM_FC_SCPH 8'h03
`define EFM_FC_TMO 8'h04
`define EFM_FC_CHK 8'h05
`define EFM_FC_PSU 8'h06
`define EFM_FC_REINIT_MAX 8'h08
`define EFM_PHASE_SAMPLES 4'ha
`define EFM_PHASE_DEG 10
`define EFM_WB_PP_UV 250000
`define EFM_CLK_NS 10
`define EFM_CHECK_NS 1000000000
`define EFM_LINK_TMO_NS 20000
`endif

/* File: shared/efm_pkg.sv */
// Purpose: Types of the encoder fault monitor
// Assumes: Constants live in efm_map.svh
// Notes: Encoder type order fixes the control field encoding
`default_nettype none
package efm_pkg;
   typedef enum logic [2:0] {
      quadrature_type,
      freq_dir_type,
      fwd_rev_type,
      quadrature_commutation_type,
      sincos_type,
      sincos_commutation_type,
      sincos_synchronous_serial_type
   } efm_enc_t;
   typedef enum logic [0:0] {
      LK_IDLE,
      LK_BITS
   } efm_link_st_t;
endpackage : efm_pkg
`default_nettype wire
